// >>> rtl/fem_pkg.sv
// Register map, field positions and command codes of the flash erase, margin and lock controller.
package fem_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_LOCK    = 8'h00;
  localparam logic [7:0] REG_CONFIG  = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_INDEX   = 8'h0c;
  localparam logic [7:0] REG_CMDWORD = 8'h10;
  localparam logic [7:0] REG_MARGIN  = 8'h14;
  localparam logic [7:0] REG_PROTECT = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_IRQ_EN_BIT = 7;
  localparam int ST_CCF_BIT     = 7;
  localparam int ST_ACCESS_ERROR_FLAG_BIT  = 5;
  localparam int ST_PVIOL_BIT   = 4;
  localparam int ST_VFU_BIT     = 1;
  localparam int ST_VFL_BIT     = 0;
  localparam int PROT_PF_BIT    = 0;
  localparam int PROT_EE_BIT    = 1;

  // ----------------------------------------------------------------
  // Lock byte, commands and values
  // ----------------------------------------------------------------
  localparam logic [17:0] LOCK_BYTE_ADDR  = 18'h3ff0f;
  localparam logic [7:0]  LOCK_RESET      = 8'hff;
  localparam logic [1:0]  KEY_ENABLED     = 2'b10;
  localparam logic [1:0]  LOCK_UNSECURED  = 2'b10;
  localparam logic [7:0]  CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0]  CMD_ERASE_SECT  = 8'h0a;
  localparam logic [2:0]  IDX_WORD0       = 3'h0;
  localparam logic [2:0]  IDX_WORD1       = 3'h1;
  localparam logic [15:0] MARGIN_NORMAL   = 16'h0000;
  localparam logic [15:0] MARGIN_ERASED   = 16'h0001;
  localparam logic [15:0] MARGIN_PROGRAM  = 16'h0002;
  localparam logic [15:0] ERASED_WORD     = 16'hffff;
  localparam logic [2:0]  PHRASE_MASK     = 3'h7;
  localparam logic [15:0] WORD_STEP       = 16'h0002;

  typedef enum logic [4:0] {
    ST_LOAD   = 5'b00001,
    ST_IDLE   = 5'b00010,
    ST_ERASE  = 5'b00100,
    ST_VERIFY = 5'b01000,
    ST_FINISH = 5'b10000
  } fem_state_t;

endpackage

// >>> rtl/fem_ctrl.sv
// Flash command sequencer: lock byte load, block and sector erase, user margin level.
//
// What this block does
// - Load lock byte from nonvolatile memory at reset.
// - Double-bit fault at load sets all lock bits.
// - Lock register readable, writes change nothing.
// - Backdoor access enabled only for field 10.
// - Lock state unsecured only for field 10.
// - Backdoor unlock forces lock state to 10.
// - Block erase code 09, address over words.
// - Clearing complete flag launches; erase, verify, complete.
// - Block erase: index not 001 is access error.
// - Block erase: disallowed mode is access error.
// - Block erase: invalid block select is access error.
// - Block erase: misaligned address is access error.
// - Block erase: protected block is protection violation.
// - Verify: upper on any, lower on uncorrectable.
// - Sector erase code 0A, address anywhere in sector.
// - Sector erase clears whole sector, verifies, completes.
// - Margin command applies level, then completes.
// - Eeprom margin eeprom only; flash margin both.
// - Margin settings 0, 1, 2 accepted.
// - Other margin settings are access errors.
// - Irq when complete flag and enable set.
`timescale 1ns/1ps

module fem_ctrl
  import fem_pkg::*;
#(
  parameter int          CMD_WORDS    = 8,
  parameter int          SECTOR_BYTES = 512,
  parameter logic [15:0] EE_BASE      = 16'h0400,
  parameter int          EE_BYTES     = 512,
  parameter logic [1:0]  PF_BLOCK_SEL = 2'b11,
  parameter logic [1:0]  EE_BLOCK_SEL = 2'b00,
  parameter logic [7:0]  CMD_MARGIN   = 8'h0e
) (
  input  wire logic        pclk,            // Bus clock, 100 MHz.
  input  wire logic        presetn,         // Asynchronous reset, active low.
  input  wire logic        psel,            // APB select.
  input  wire logic        penable,         // APB access phase.
  input  wire logic        pwrite,          // APB write.
  input  wire logic [7:0]  paddr,           // APB byte address.
  input  wire logic [31:0] pwdata,          // APB write data.
  output logic      [31:0] prdata,          // APB read data.
  output logic             pready,          // APB ready.
  output logic             pslverr,         // APB error on unmapped address.
  output logic             lock_rd_req,     // Lock byte read request.
  output logic      [17:0] lock_rd_addr,    // Lock byte global address.
  input  wire logic        lock_rd_valid,   // Lock byte read answer.
  input  wire logic [7:0]  lock_rd_data,    // Lock byte value.
  input  wire logic        lock_rd_dbl,     // Double-bit fault on that read.
  input  wire logic        backdoor_unlock, // Key match pulse.
  input  wire logic        cmd_mode_ok,     // Commands allowed in this mode.
  output logic             arr_req,         // Array access request.
  output logic             arr_erase,       // 1 erase word, 0 read word.
  output logic      [16:0] arr_addr,        // Array word address.
  input  wire logic        arr_ack,         // Array access done.
  input  wire logic [15:0] arr_rdata,       // Read data.
  input  wire logic        arr_sbe,         // Corrected error on read.
  input  wire logic        arr_dbe,         // Uncorrectable error on read.
  output logic      [1:0]  pf_margin,       // Program flash read margin.
  output logic      [1:0]  ee_margin,       // Eeprom read margin.
  output logic             device_secured,  // Lock state is secured.
  output logic             backdoor_en,     // Backdoor key access enabled.
  output logic             cmd_irq          // Command complete interrupt.
);

  localparam logic [15:0] SECT_MASK = 16'(SECTOR_BYTES - 1);
  localparam logic [15:0] EE_LAST   = 16'(int'(EE_BASE) + EE_BYTES - 2);
  localparam logic [15:0] PF_LAST   = 16'hfffe;
  localparam logic [15:0] SECT_LAST = 16'(SECTOR_BYTES - 2);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  fem_state_t  state;
  logic [7:0]  lock;
  logic        irq_en;
  logic        ccf;
  logic        access_error_flag;
  logic        pviol;
  logic        vf_upper;
  logic        vf_lower;
  logic [2:0]  cmd_idx;
  logic [15:0] cmd_arr [CMD_WORDS];
  logic [1:0]  protect;
  logic [1:0]  op_blk;
  logic [15:0] op_first;
  logic [15:0] op_cur;
  logic [15:0] op_last;

  logic        wr_acc;
  logic        rd_setup;
  logic        hit;
  logic        launch;
  logic [7:0]  cmd_code;
  logic [1:0]  cmd_blk;
  logic [15:0] cmd_addr;
  logic        blk_pf;
  logic        blk_ee;
  logic        acc_fail;
  logic        prot_fail;
  logic        margin_ok;
  logic        erase_go;
  logic        bd_take;
  logic        v_err;
  logic        v_dbl;
  logic [15:0] sect_first;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  always_comb begin
    unique case (paddr)
      REG_LOCK, REG_CONFIG, REG_STATUS, REG_INDEX,
      REG_CMDWORD, REG_MARGIN, REG_PROTECT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;

  // Read data is captured in the setup cycle so it comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        REG_LOCK:    prdata <= {24'h00_0000, lock};
        REG_CONFIG:  prdata <= 32'(irq_en) << CFG_IRQ_EN_BIT;
        REG_STATUS:  prdata <= (32'(ccf) << ST_CCF_BIT) | (32'(access_error_flag) << ST_ACCESS_ERROR_FLAG_BIT)
                               | (32'(pviol) << ST_PVIOL_BIT) | (32'(vf_upper) << ST_VFU_BIT)
                               | (32'(vf_lower) << ST_VFL_BIT);
        REG_INDEX:   prdata <= {29'h0000_0000, cmd_idx};
        REG_CMDWORD: prdata <= {16'h0000, cmd_arr[cmd_idx]};
        REG_MARGIN:  prdata <= {28'h000_0000, ee_margin, pf_margin};
        REG_PROTECT: prdata <= {30'h0000_0000, protect};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en  <= 1'b0;
      protect <= 2'b00;
    end else if (wr_acc) begin
      if (paddr == REG_CONFIG) begin
        irq_en <= pwdata[CFG_IRQ_EN_BIT];
      end
      if (paddr == REG_PROTECT) begin
        protect <= pwdata[1:0];
      end
    end
  end

  // Index and parameter words are frozen while a command runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_idx <= 3'h0;
    end else if (wr_acc && paddr == REG_INDEX && ccf) begin
      cmd_idx <= pwdata[2:0];
    end
  end

  for (genvar i = 0; i < CMD_WORDS; i++) begin : g_cmd
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cmd_arr[i] <= 16'h0000;
      end else if (wr_acc && paddr == REG_CMDWORD && ccf && cmd_idx == 3'(i)) begin
        cmd_arr[i] <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock byte
  // ----------------------------------------------------------------
  assign lock_rd_req    = (state == ST_LOAD);
  assign lock_rd_addr   = LOCK_BYTE_ADDR;
  assign backdoor_en    = (lock[7:6] == KEY_ENABLED);
  assign device_secured = (lock[1:0] != LOCK_UNSECURED);
  assign bd_take        = backdoor_unlock & backdoor_en & (state != ST_LOAD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= LOCK_RESET;
    end else if (state == ST_LOAD && lock_rd_valid) begin
      lock <= lock_rd_dbl ? LOCK_RESET : lock_rd_data;
    end else if (bd_take) begin
      lock[1:0] <= LOCK_UNSECURED;
    end
  end

  // ----------------------------------------------------------------
  // Launch checks
  // ----------------------------------------------------------------
  assign cmd_code   = cmd_arr[IDX_WORD0][15:8];
  assign cmd_blk    = cmd_arr[IDX_WORD0][1:0];
  assign cmd_addr   = cmd_arr[IDX_WORD1];
  assign blk_pf     = (cmd_blk == PF_BLOCK_SEL);
  assign blk_ee     = (cmd_blk == EE_BLOCK_SEL);
  assign sect_first = cmd_addr & ~SECT_MASK;
  assign margin_ok  = (cmd_addr == MARGIN_NORMAL) || (cmd_addr == MARGIN_ERASED)
                      || (cmd_addr == MARGIN_PROGRAM);
  assign launch     = wr_acc && paddr == REG_STATUS && pwdata[ST_CCF_BIT]
                      && ccf && state == ST_IDLE;

  always_comb begin
    acc_fail  = (cmd_idx != IDX_WORD1) || !cmd_mode_ok;
    prot_fail = 1'b0;
    unique case (cmd_code)
      CMD_ERASE_BLOCK: begin
        acc_fail = acc_fail || !(blk_pf || blk_ee)
                   || (blk_pf && (cmd_addr[2:0] & PHRASE_MASK) != 3'h0)
                   || (blk_ee && cmd_addr[0]);
        prot_fail = (blk_pf && protect[PROT_PF_BIT])
                    || (blk_ee && protect[PROT_EE_BIT]);
      end
      CMD_ERASE_SECT: begin
        acc_fail  = acc_fail || !blk_pf;
        prot_fail = protect[PROT_PF_BIT];
      end
      CMD_MARGIN: begin
        acc_fail = acc_fail || !(blk_pf || blk_ee) || !margin_ok;
      end
      default: acc_fail = 1'b1;
    endcase
  end

  assign erase_go = launch && !acc_fail && !prot_fail
                    && (cmd_code == CMD_ERASE_BLOCK || cmd_code == CMD_ERASE_SECT);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_LOAD;
    end else begin
      unique case (state)
        ST_LOAD:   if (lock_rd_valid) state <= ST_IDLE;
        ST_IDLE:   if (erase_go) state <= ST_ERASE; else if (launch) state <= ST_FINISH;
        ST_ERASE:  if (arr_ack && op_cur == op_last) state <= ST_VERIFY;
        ST_VERIFY: if (arr_ack && op_cur == op_last) state <= ST_FINISH;
        ST_FINISH: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_blk   <= 2'b00;
      op_first <= 16'h0000;
      op_cur   <= 16'h0000;
      op_last  <= 16'h0000;
    end else if (erase_go) begin
      op_blk <= cmd_blk;
      if (cmd_code == CMD_ERASE_SECT) begin
        op_first <= sect_first;
        op_cur   <= sect_first;
        op_last  <= sect_first + SECT_LAST;
      end else begin
        op_first <= blk_pf ? 16'h0000 : EE_BASE;
        op_cur   <= blk_pf ? 16'h0000 : EE_BASE;
        op_last  <= blk_pf ? PF_LAST : EE_LAST;
      end
    end else if (arr_ack && (state == ST_ERASE || state == ST_VERIFY)) begin
      op_cur <= (op_cur == op_last) ? op_first : op_cur + WORD_STEP;
    end
  end

  assign arr_req   = (state == ST_ERASE) || (state == ST_VERIFY);
  assign arr_erase = (state == ST_ERASE);
  assign arr_addr  = {op_blk, op_cur[15:1]};

  assign v_err = (arr_rdata != ERASED_WORD) || arr_sbe || arr_dbe;
  assign v_dbl = (arr_rdata != ERASED_WORD) || arr_dbe;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccf <= 1'b0;
    end else if (state == ST_FINISH || (state == ST_LOAD && lock_rd_valid)) begin
      ccf <= 1'b1;
    end else if (launch) begin
      ccf <= 1'b0;
    end
  end

  // A set on launch wins over the clear carried by the same write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_error_flag <= 1'b0;
      pviol  <= 1'b0;
    end else begin
      if (launch && acc_fail) begin
        access_error_flag <= 1'b1;
      end else if (wr_acc && paddr == REG_STATUS && pwdata[ST_ACCESS_ERROR_FLAG_BIT]) begin
        access_error_flag <= 1'b0;
      end
      if (launch && !acc_fail && prot_fail) begin
        pviol <= 1'b1;
      end else if (wr_acc && paddr == REG_STATUS && pwdata[ST_PVIOL_BIT]) begin
        pviol <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vf_upper <= 1'b0;
      vf_lower <= 1'b0;
    end else if (launch) begin
      vf_upper <= 1'b0;
      vf_lower <= 1'b0;
    end else if (state == ST_VERIFY && arr_ack) begin
      vf_upper <= vf_upper | v_err;
      vf_lower <= vf_lower | v_dbl;
    end
  end

  // ----------------------------------------------------------------
  // Margin levels and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_margin <= 2'b00;
      ee_margin <= 2'b00;
    end else if (launch && cmd_code == CMD_MARGIN && !acc_fail) begin
      ee_margin <= cmd_addr[1:0];
      if (blk_pf) begin
        pf_margin <= cmd_addr[1:0];
      end
    end
  end

  assign cmd_irq = ccf & irq_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  lock_load_a: assert property (state == ST_LOAD && lock_rd_valid && !lock_rd_dbl |=>
    lock == $past(lock_rd_data) && ccf) else $error("lock byte not loaded");
  dbl_fault_a: assert property (state == ST_LOAD && lock_rd_valid && lock_rd_dbl |=>
    lock == LOCK_RESET && device_secured && !backdoor_en) else $error("fault load not locked");
  lock_ro_a: assert property (state != ST_LOAD && !backdoor_unlock |=>
    $stable(lock)) else $error("lock register changed");
  key_gate_a: assert property (backdoor_unlock && lock[7:6] != KEY_ENABLED |=>
    $stable(lock)) else $error("backdoor taken while disabled");
  unsecure_a: assert property (bd_take |=> !device_secured && lock[1:0] == 2'b10)
    else $error("backdoor did not unsecure");
  bad_index_a: assert property (launch && cmd_code == CMD_ERASE_BLOCK && cmd_idx != 3'h1
    |=> access_error_flag && !ccf ##1 ccf && state == ST_IDLE) else $error("index error missed");
  mode_err_a: assert property (launch && !cmd_mode_ok |=> access_error_flag && state == ST_FINISH)
    else $error("mode error missed");
  protect_a: assert property (launch && cmd_code == CMD_ERASE_BLOCK && !acc_fail
    && ((blk_pf && protect[PROT_PF_BIT]) || (blk_ee && protect[PROT_EE_BIT]))
    |=> pviol && !arr_req) else $error("protection missed");
  busy_a: assert property (arr_req |-> !ccf) else $error("complete while busy");
  verify_a: assert property (state == ST_VERIFY && arr_ack && arr_dbe |=>
    vf_upper && vf_lower) else $error("verify fault missed");
  margin_a: assert property (launch && cmd_code == CMD_MARGIN && !acc_fail && blk_ee
    |=> ee_margin == $past(cmd_addr[1:0]) && $stable(pf_margin) ##1 ccf)
    else $error("margin not applied");
  irq_a: assert property ($rose(ccf) && irq_en |-> cmd_irq) else $error("irq missing");

  blk_erase_c: cover property (state == ST_VERIFY && arr_ack && op_cur == op_last
    && op_first == 16'h0000 ##1 state == ST_FINISH);
  sect_erase_c: cover property (erase_go && cmd_code == CMD_ERASE_SECT ##1 state == ST_ERASE);
  margin_c: cover property (launch && cmd_code == CMD_MARGIN && !acc_fail && blk_pf);
  dbl_load_c: cover property (state == ST_LOAD && lock_rd_valid && lock_rd_dbl);

endmodule

// >>> tb/tb.sv
// Self-checking bench for the flash erase, margin and lock controller.
`timescale 1ns/1ps

module tb;
  import fem_pkg::*;

  // ----------------------------------------------------------------
  // Constants and signals
  // ----------------------------------------------------------------
  localparam int          SB   = 16;
  localparam int          EB   = 16;
  localparam logic [31:0] CCF  = 32'h1 << ST_CCF_BIT;
  localparam logic [31:0] ACC  = 32'h1 << ST_ACCESS_ERROR_FLAG_BIT;
  localparam logic [31:0] PV   = 32'h1 << ST_PVIOL_BIT;
  localparam logic [31:0] VU   = 32'h1 << ST_VFU_BIT;
  localparam logic [31:0] VL   = 32'h1 << ST_VFL_BIT;
  localparam logic [31:0] MASK = CCF | ACC | PV | VU | VL;
  localparam logic [1:0]  EE_BLOCK_SEL_V = 2'b00;
  localparam logic [1:0]  PF_BLOCK_SEL_V = 2'b11;
  localparam logic [15:0] EE_BASE_V      = 16'h0400;
  localparam logic [15:0] EEB  = {CMD_ERASE_BLOCK, 6'h0, EE_BLOCK_SEL_V};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, lock_rd_data;
  logic [31:0] pwdata, prdata, q, st;
  logic        lock_rd_req, lock_rd_valid, lock_rd_dbl, backdoor_unlock, cmd_mode_ok;
  logic [17:0] lock_rd_addr;
  logic        arr_req, arr_erase, arr_ack, arr_sbe, arr_dbe, e;
  logic [16:0] arr_addr, first_addr;
  logic [15:0] arr_rdata;
  logic [1:0]  pf_margin, ee_margin;
  logic        device_secured, backdoor_en, cmd_irq, inj_sbe, inj_dbe;
  int          n_er, n_rd, err_total, n_tests;

  fem_ctrl #(.SECTOR_BYTES(SB), .EE_BYTES(EB)) u_fem_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lock_rd_req(lock_rd_req), .lock_rd_addr(lock_rd_addr), .lock_rd_valid(lock_rd_valid),
    .lock_rd_data(lock_rd_data), .lock_rd_dbl(lock_rd_dbl), .backdoor_unlock(backdoor_unlock),
    .cmd_mode_ok(cmd_mode_ok), .arr_req(arr_req), .arr_erase(arr_erase),
    .arr_addr(arr_addr), .arr_ack(arr_ack), .arr_rdata(arr_rdata), .arr_sbe(arr_sbe),
    .arr_dbe(arr_dbe), .pf_margin(pf_margin), .ee_margin(ee_margin),
    .device_secured(device_secured), .backdoor_en(backdoor_en), .cmd_irq(cmd_irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Array answers every other cycle and counts the words it sees.
  always @(posedge pclk) begin
    arr_ack <= arr_req && !arr_ack;
    arr_sbe <= inj_sbe;
    arr_dbe <= inj_dbe;
    if (arr_req && arr_ack) begin
      if (arr_erase) begin
        if (n_er == 0) first_addr = arr_addr;
        n_er++;
      end else n_rd++;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input logic [7:0] d, input logic dbl);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(lock_rd_req, 1'b1, "load request");
    chk(lock_rd_addr, LOCK_BYTE_ADDR, "load address");
    lock_rd_data <= d;
    lock_rd_dbl <= dbl;
    lock_rd_valid <= 1'b1;
    @(posedge pclk);
    lock_rd_valid <= 1'b0;
    lock_rd_dbl <= 1'b0;
  endtask

  task automatic cmd(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] ix);
    int n;
    apb(1'b1, REG_INDEX, {29'h0, IDX_WORD0});
    apb(1'b1, REG_CMDWORD, {16'h0, w0});
    apb(1'b1, REG_INDEX, {29'h0, IDX_WORD1});
    apb(1'b1, REG_CMDWORD, {16'h0, w1});
    apb(1'b1, REG_INDEX, {29'h0, ix});
    apb(1'b1, REG_STATUS, ACC | PV);
    n_er = 0;
    n_rd = 0;
    apb(1'b1, REG_STATUS, CCF);
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[ST_CCF_BIT] !== 1'b1 && n < 500);
    st = q & MASK;
  endtask

  task automatic err_case(input logic [15:0] w0, w1, input logic [2:0] ix,
                          input logic [31:0] exp);
    cmd(w0, w1, ix);
    chk(st, CCF | exp, "error flags");
    chk(n_er, 0, "no erase on error");
  endtask

  task automatic pulse_key();
    @(posedge pclk);
    backdoor_unlock <= 1'b1;
    @(posedge pclk);
    backdoor_unlock <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_lock();
    logic [1:0] k;
    for (int v = 0; v < 4; v++) begin
      k = 2'(v);
      do_reset({k, 4'hf, k}, 1'b0);
      apb(1'b0, REG_LOCK, 32'h0);
      chk(q, {24'h0, k, 4'hf, k}, "lock load");
      chk(backdoor_en, k == KEY_ENABLED, "key enable");
      chk(device_secured, k != LOCK_UNSECURED, "secured");
    end
    do_reset(8'h82, 1'b1);
    pulse_key();
    apb(1'b0, REG_LOCK, 32'h0);
    chk(q, {24'h0, LOCK_RESET}, "fault load");
    do_reset(8'h81, 1'b0);
    apb(1'b1, REG_LOCK, 32'h0);
    apb(1'b0, REG_LOCK, 32'h0);
    chk(q, 32'h81, "lock write ignored");
    pulse_key();
    apb(1'b0, REG_LOCK, 32'h0);
    chk(q, 32'h82, "backdoor unlock");
    chk(device_secured, 1'b0, "unsecured");
  endtask

  task automatic t_erase();
    logic [15:0] b;
    apb(1'b1, REG_PROTECT, 32'h0);
    cmd(EEB, EE_BASE_V, IDX_WORD1);
    chk(st, CCF, "block erase done");
    chk(n_er, EB / 2, "erased words");
    chk(n_rd, EB / 2, "verified words");
    chk(first_addr, {EE_BLOCK_SEL_V, EE_BASE_V[15:1]}, "block start");
    inj_sbe = 1'b1;
    cmd(EEB, EE_BASE_V, IDX_WORD1);
    chk(st, CCF | VU, "corrected fault");
    inj_sbe = 1'b0;
    inj_dbe = 1'b1;
    cmd(EEB, EE_BASE_V, IDX_WORD1);
    chk(st, CCF | VU | VL, "uncorrectable fault");
    inj_dbe = 1'b0;
    b = 16'h1235 & ~16'(SB - 1);
    cmd({CMD_ERASE_SECT, 6'h0, PF_BLOCK_SEL_V}, 16'h1235, IDX_WORD1);
    chk(st, CCF, "sector done");
    chk(n_er, SB / 2, "sector words");
    chk(n_rd, SB / 2, "sector verify");
    chk(first_addr, {PF_BLOCK_SEL_V, b[15:1]}, "sector start");
  endtask

  task automatic t_errors();
    err_case(EEB, EE_BASE_V, IDX_WORD0, ACC);
    @(posedge pclk);
    cmd_mode_ok <= 1'b0;
    err_case(EEB, EE_BASE_V, IDX_WORD1, ACC);
    cmd_mode_ok <= 1'b1;
    err_case({CMD_ERASE_BLOCK, 8'h01}, 16'h0, IDX_WORD1, ACC);
    err_case(EEB, EE_BASE_V + 16'h1, IDX_WORD1, ACC);
    err_case({CMD_ERASE_BLOCK, 6'h0, PF_BLOCK_SEL_V}, 16'h8003, IDX_WORD1, ACC);
    apb(1'b1, REG_PROTECT, 32'h1 << PROT_EE_BIT);
    err_case(EEB, EE_BASE_V, IDX_WORD1, PV);
    apb(1'b1, REG_PROTECT, 32'h0);
    err_case({8'h0e, 6'h0, EE_BLOCK_SEL_V}, 16'h0003, IDX_WORD1, ACC);
  endtask

  task automatic t_margin();
    cmd({8'h0e, 6'h0, EE_BLOCK_SEL_V}, MARGIN_ERASED, IDX_WORD1);
    chk(st, CCF, "margin done");
    chk({ee_margin, pf_margin}, {MARGIN_ERASED[1:0], 2'b00}, "eeprom only");
    cmd({8'h0e, 6'h0, PF_BLOCK_SEL_V}, MARGIN_PROGRAM, IDX_WORD1);
    apb(1'b0, REG_MARGIN, 32'h0);
    chk(q, {28'h0, MARGIN_PROGRAM[1:0], MARGIN_PROGRAM[1:0]}, "flash both");
    cmd({8'h0e, 6'h0, PF_BLOCK_SEL_V}, MARGIN_NORMAL, IDX_WORD1);
    chk({ee_margin, pf_margin}, 4'h0, "normal level");
  endtask

  task automatic t_bus();
    apb(1'b1, REG_CONFIG, 32'h1 << CFG_IRQ_EN_BIT);
    @(negedge pclk);
    chk(cmd_irq, 1'b1, "irq on");
    apb(1'b1, REG_CONFIG, 32'h0);
    @(negedge pclk);
    chk(cmd_irq, 1'b0, "irq masked");
    apb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0, "unmapped read data");
    chk({31'h0, e}, 32'h1, "unmapped read error");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, lock_rd_valid, lock_rd_dbl, backdoor_unlock} = '0;
    {paddr, pwdata, lock_rd_data, arr_ack, arr_sbe, arr_dbe, inj_sbe, inj_dbe} = '0;
    {n_er, n_rd, err_total, n_tests} = '0;
    cmd_mode_ok = 1'b1;
    arr_rdata = ERASED_WORD;
    t_lock();
    t_erase();
    t_errors();
    t_margin();
    t_bus();
    summarize();
  end

  initial begin
    #400000;
    err_total++;
    summarize();
  end

endmodule
